/* File: logic/epaper_spi_command_port.sv */
`timescale 1ns/1ps
module epaper_spi_command_port #(
  parameter int REFRESH_CYCLES = epd_cmd_pkg::REFRESH_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  // Serial pins
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic dc_in,
  input wire logic serial_data_line_in,
  input wire logic reserved_data_line_a_in,
  input wire logic reserved_data_line_b_in,
  input wire logic reserved_data_line_c_in,
  // Straps
  input wire logic interface_strap_a_in,
  input wire logic interface_strap_b_in,
  // Background work from other engines
  input wire logic otp_busy_in,
  input wire logic sensor_busy_in,
  // Data line drive (never driven, write-only port)
  output logic serial_data_line_out,
  output logic serial_data_line_oe_out,
  output logic reserved_data_line_a_out,
  output logic reserved_data_line_a_oe_out,
  output logic reserved_data_line_b_out,
  output logic reserved_data_line_b_oe_out,
  output logic reserved_data_line_c_out,
  output logic reserved_data_line_c_oe_out,
  // Status and controls
  output logic busy_n_out,
  output logic supplies_on_out,
  output logic deep_sleep_out,
  output logic refresh_active_out,
  output epd_cmd_pkg::ram_write_t ram_wr_out
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;

  // Busy sources are synchronised apart, then combined
  assign pins_raw = {cs_n_in, sclk_in, dc_in, serial_data_line_in,
                     interface_strap_a_in, interface_strap_b_in,
                     otp_busy_in, sensor_busy_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          sync1_r[gi] <= (gi == NSYNC - 1) ? 1'b1 : 1'b0;
          sync2_r[gi] <= (gi == NSYNC - 1) ? 1'b1 : 1'b0;
        end else if (clk_en_in) begin
          sync1_r[gi] <= pins_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  logic cs_n_s;
  logic sclk_s;
  logic dc_s;
  logic sdata_s;
  logic strap_a_s;
  logic strap_b_s;
  logic bg_busy_s;

  assign cs_n_s = sync2_r[7];
  assign sclk_s = sync2_r[6];
  assign dc_s = sync2_r[5];
  assign sdata_s = sync2_r[4];
  assign strap_a_s = sync2_r[3];
  assign strap_b_s = sync2_r[2];
  assign bg_busy_s = sync2_r[1] | sync2_r[0];

  // ---------------------------------------------------------------
  // Interface selection
  // ---------------------------------------------------------------
  // Straps are caught once after reset release; live changes are ignored
  logic strap_taken_r;
  logic three_line_r;
  logic [1:0] strap_wait_r;

  // Both synchroniser stages must hold the pin before it is trusted
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strap_wait_r <= 2'b00;
      strap_taken_r <= 1'b0;
      three_line_r <= 1'b0;
    end else if (clk_en_in) begin
      strap_wait_r <= {strap_wait_r[0], 1'b1};
      if (strap_wait_r[1] && !strap_taken_r) begin
        strap_taken_r <= 1'b1;
        three_line_r <= strap_a_s & ~strap_b_s;
      end
    end
  end

  // ---------------------------------------------------------------
  // Byte receiver
  // ---------------------------------------------------------------
  epd_cmd_pkg::rx_byte_t rx_byte;
  logic rx_valid;
  logic rx_gate;

  // Sleeping controller ignores serial traffic entirely
  assign rx_gate = cs_n_s | ~strap_taken_r | deep_sleep_out;

  serial_rx u_rx (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .clk_en_in(clk_en_in),
    .cs_n_in(rx_gate),
    .sclk_in(sclk_s),
    .sdata_in(sdata_s),
    .dc_in(dc_s),
    .three_line_in(three_line_r),
    .byte_out(rx_byte),
    .byte_valid_out(rx_valid)
  );

  // ---------------------------------------------------------------
  // Refresh timer
  // ---------------------------------------------------------------
  logic refresh_start;
  logic refresh_running;
  logic refresh_done;

  busy_timer #(
    .CYCLES(REFRESH_CYCLES)
  ) u_timer (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .clk_en_in(clk_en_in),
    .start_in(refresh_start),
    .running_out(refresh_running),
    .done_out(refresh_done)
  );

  // ---------------------------------------------------------------
  // Command decoder
  // ---------------------------------------------------------------
  epd_cmd_pkg::cmd_state_t state_r;
  epd_cmd_pkg::cmd_state_t state_nxt;
  logic is_cmd;
  logic is_dat;
  logic refresh_ok;

  assign is_cmd = rx_valid & ~rx_byte.is_data;
  assign is_dat = rx_valid & rx_byte.is_data;
  assign refresh_ok = rx_byte.value == epd_cmd_pkg::PARAM_REFRESH;
  // Any other refresh parameter is dropped and the decoder idles
  assign refresh_start = is_dat && refresh_ok &&
                         (state_r == epd_cmd_pkg::ST_REFRESH_PARAM);

  always_comb begin
    state_nxt = state_r;
    if (is_cmd) begin
      unique case (rx_byte.value)
        epd_cmd_pkg::CMD_POWER_OFF: state_nxt = epd_cmd_pkg::ST_OFF_PARAM;
        epd_cmd_pkg::CMD_DEEP_SLEEP: state_nxt = epd_cmd_pkg::ST_SLEEP_PARAM;
        epd_cmd_pkg::CMD_DATA_START: state_nxt = epd_cmd_pkg::ST_DATA_STREAM;
        epd_cmd_pkg::CMD_REFRESH: state_nxt = epd_cmd_pkg::ST_REFRESH_PARAM;
        default: state_nxt = epd_cmd_pkg::ST_IDLE;
      endcase
    end else if (is_dat) begin
      unique case (state_r)
        epd_cmd_pkg::ST_DATA_STREAM: state_nxt = epd_cmd_pkg::ST_DATA_STREAM;
        epd_cmd_pkg::ST_SLEEP_PARAM: begin
          state_nxt = (rx_byte.value == epd_cmd_pkg::PARAM_DEEP_SLEEP) ?
                      epd_cmd_pkg::ST_SLEEPING : epd_cmd_pkg::ST_IDLE;
        end
        epd_cmd_pkg::ST_SLEEPING: state_nxt = epd_cmd_pkg::ST_SLEEPING;
        default: state_nxt = epd_cmd_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= epd_cmd_pkg::ST_IDLE;
    end else if (clk_en_in) begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Byte decode
  // ---------------------------------------------------------------
  // This block names the power, data-start and stream bytes the controls use; the command decoder also matches CMD_DATA_START
  logic power_on_cmd;
  logic power_off_ok;
  logic data_start_cmd;
  logic stream_byte;

  assign power_on_cmd = is_cmd && rx_byte.value == epd_cmd_pkg::CMD_POWER_ON;
  assign power_off_ok = is_dat && state_r == epd_cmd_pkg::ST_OFF_PARAM &&
                        rx_byte.value == epd_cmd_pkg::PARAM_POWER_OFF;
  assign data_start_cmd = is_cmd &&
                          rx_byte.value == epd_cmd_pkg::CMD_DATA_START;
  assign stream_byte = is_dat && state_r == epd_cmd_pkg::ST_DATA_STREAM;

  // ---------------------------------------------------------------
  // Power and sleep controls
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      supplies_on_out <= 1'b0;
      deep_sleep_out <= 1'b0;
    end else if (clk_en_in) begin
      if (power_on_cmd) begin
        supplies_on_out <= 1'b1;
      end else if (power_off_ok) begin
        supplies_on_out <= 1'b0;
      end
      // Sleep is left only through the reset branch above
      if (state_nxt == epd_cmd_pkg::ST_SLEEPING) begin
        deep_sleep_out <= 1'b1;
        supplies_on_out <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Display RAM stream
  // ---------------------------------------------------------------
  // Address wraps at the frame end so a long stream never runs off RAM
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ram_wr_out <= '0;
    end else if (clk_en_in) begin
      ram_wr_out.wr_en <= 1'b0;
      if (stream_byte) begin
        ram_wr_out.wr_en <= 1'b1;
        ram_wr_out.data <= rx_byte.value;
      end
      // A restart wins over the step after a write in the same cycle
      if (data_start_cmd) begin
        ram_wr_out.addr <= epd_cmd_pkg::RAM_ADDR_RESET;
      end else if (ram_wr_out.wr_en) begin
        ram_wr_out.addr <= (ram_wr_out.addr == epd_cmd_pkg::RAM_ADDR_LAST) ?
                           epd_cmd_pkg::RAM_ADDR_RESET :
                           ram_wr_out.addr + 18'h00001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Busy output
  // ---------------------------------------------------------------
  // Commands during busy are not blocked; the host must hold off
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_n_out <= 1'b1;
      refresh_active_out <= 1'b0;
    end else if (clk_en_in) begin
      refresh_active_out <= refresh_running | refresh_start;
      busy_n_out <= ~(refresh_start | (refresh_running & ~refresh_done)
                      | bg_busy_s);
    end
  end

  // ---------------------------------------------------------------
  // Data line drivers
  // ---------------------------------------------------------------
  // Write-only link: no line is ever driven
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      serial_data_line_out <= 1'b0;
      serial_data_line_oe_out <= 1'b0;
      reserved_data_line_a_out <= 1'b0;
      reserved_data_line_a_oe_out <= 1'b0;
      reserved_data_line_b_out <= 1'b0;
      reserved_data_line_b_oe_out <= 1'b0;
      reserved_data_line_c_out <= 1'b0;
      reserved_data_line_c_oe_out <= 1'b0;
    end
  end

endmodule

/* File: logic/epd_cmd_pkg.sv */
package epd_cmd_pkg;

  // ---------------------------------------------------------------
  // Command codes and check bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_POWER_OFF = 8'h02;
  localparam logic [7:0] CMD_POWER_ON = 8'h04;
  localparam logic [7:0] CMD_DEEP_SLEEP = 8'h07;
  localparam logic [7:0] CMD_DATA_START = 8'h10;
  localparam logic [7:0] CMD_REFRESH = 8'h12;
  localparam logic [7:0] PARAM_POWER_OFF = 8'h00;
  localparam logic [7:0] PARAM_DEEP_SLEEP = 8'ha5;
  localparam logic [7:0] PARAM_REFRESH = 8'h01;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int BYTE_BITS = 8;
  localparam int FRAME3_BITS = 9;
  localparam logic [3:0] BITS_4LINE = 4'h8;
  localparam logic [3:0] BITS_3LINE = 4'h9;

  // ---------------------------------------------------------------
  // Display RAM and timing
  // ---------------------------------------------------------------
  localparam int RAM_ADDR_BITS = 18;
  localparam logic [17:0] RAM_ADDR_RESET = 18'h00000;
  localparam logic [17:0] RAM_ADDR_LAST = 18'h2edff;
  localparam int CLK_PERIOD_NS = 10;
  localparam int REFRESH_TIME_US = 1000;
  localparam int REFRESH_CYCLES = REFRESH_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int COUNT_BITS = 24;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic is_data;
    logic [7:0] value;
  } rx_byte_t;

  typedef struct packed {
    logic wr_en;
    logic [17:0] addr;
    logic [7:0] data;
  } ram_write_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OFF_PARAM = 3'b001,
    ST_SLEEP_PARAM = 3'b010,
    ST_DATA_STREAM = 3'b011,
    ST_REFRESH_PARAM = 3'b100,
    ST_SLEEPING = 3'b101
  } cmd_state_t;

endpackage

/* File: logic/serial_rx.sv */
`timescale 1ns/1ps
module serial_rx (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  // Synchronised serial pins
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic sdata_in,
  input wire logic dc_in,
  input wire logic three_line_in,
  // Received byte
  output epd_cmd_pkg::rx_byte_t byte_out,
  output logic byte_valid_out
);

  logic sclk_d_r;
  logic [7:0] shift_r;
  logic [3:0] count_r;
  logic [3:0] frame_len;
  logic rise;
  logic [8:0] shifted;

  assign frame_len = three_line_in ? epd_cmd_pkg::BITS_3LINE :
                     epd_cmd_pkg::BITS_4LINE;
  assign rise = sclk_in & ~sclk_d_r;
  assign shifted = {shift_r[7:0], sdata_in};

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sclk_d_r <= 1'b0;
    end else if (clk_en_in) begin
      sclk_d_r <= sclk_in;
    end
  end

  // Bit counter restarts whenever chip select is released
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      shift_r <= 8'h00;
      count_r <= 4'h0;
    end else if (clk_en_in) begin
      if (cs_n_in) begin
        count_r <= 4'h0;
      end else if (rise) begin
        shift_r <= shifted[7:0];
        count_r <= (count_r + 4'h1 == frame_len) ? 4'h0 : count_r + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      byte_out <= '0;
      byte_valid_out <= 1'b0;
    end else if (clk_en_in) begin
      byte_valid_out <= 1'b0;
      if (!cs_n_in && rise && (count_r + 4'h1 == frame_len)) begin
        byte_valid_out <= 1'b1;
        byte_out.value <= shifted[7:0];
        // 3-line frames carry the flag as their first bit
        byte_out.is_data <= three_line_in ? shifted[8] : dc_in;
      end
    end
  end

endmodule

/* File: logic/busy_timer.sv */
`timescale 1ns/1ps
module busy_timer #(
  parameter int CYCLES = epd_cmd_pkg::REFRESH_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  input wire logic start_in,
  output logic running_out,
  output logic done_out
);

  logic [23:0] count_r;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_r <= 24'h000000;
      running_out <= 1'b0;
      done_out <= 1'b0;
    end else if (clk_en_in) begin
      done_out <= 1'b0;
      if (start_in && !running_out) begin
        running_out <= 1'b1;
        count_r <= 24'(CYCLES - 1);
      end else if (running_out) begin
        if (count_r == 24'h000000) begin
          running_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          count_r <= count_r - 24'h000001;
        end
      end
    end
  end

endmodule

/* File: test/epd_port_sva.sv */
`timescale 1ns/1ps
module epd_port_sva #(
  parameter int REFRESH_CYCLES = epd_cmd_pkg::REFRESH_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic cs_n_in,
  input wire logic otp_busy_in,
  input wire logic sensor_busy_in,
  input wire logic serial_data_line_oe_out,
  input wire logic reserved_data_line_a_oe_out,
  input wire logic reserved_data_line_b_oe_out,
  input wire logic reserved_data_line_c_oe_out,
  input wire logic busy_n_out,
  input wire logic supplies_on_out,
  input wire logic deep_sleep_out,
  input wire logic refresh_active_out,
  input wire epd_cmd_pkg::ram_write_t ram_wr_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  // Length of the current refresh, for the duration checks
  logic [15:0] act_cnt_r;
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      act_cnt_r <= 16'h0000;
    end else if (refresh_active_out) begin
      act_cnt_r <= act_cnt_r + 16'h0001;
    end else begin
      act_cnt_r <= 16'h0000;
    end
  end
  sequence s_cs_idle;
    cs_n_in [*8];
  endsequence
  sequence s_bg_start;
    $rose(otp_busy_in || sensor_busy_in);
  endsequence
  sequence s_refresh_end;
    $fell(refresh_active_out) && !otp_busy_in && !sensor_busy_in;
  endsequence
  a_lines_quiet: assert property (
    !(serial_data_line_oe_out || reserved_data_line_a_oe_out ||
      reserved_data_line_b_oe_out || reserved_data_line_c_oe_out))
    else $error("data line driven");
  a_bg_busy: assert property (s_bg_start |-> ##[1:5] !busy_n_out)
    else $error("background work left busy high");
  a_refresh_busy: assert property ($rose(refresh_active_out) |->
    !busy_n_out ##1 !busy_n_out [*8])
    else $error("busy high during refresh");
  a_refresh_len: assert property ($fell(refresh_active_out) |->
    act_cnt_r >= REFRESH_CYCLES - 2 && act_cnt_r <= REFRESH_CYCLES + 2)
    else $error("refresh length wrong");
  a_busy_return: assert property (s_refresh_end |-> ##[0:3] busy_n_out)
    else $error("busy not released");
  a_sleep_quiet: assert property (deep_sleep_out |-> !ram_wr_out.wr_en)
    else $error("ram write while asleep");
  a_sleep_sticky: assert property (deep_sleep_out |=> deep_sleep_out)
    else $error("left sleep without reset");
  a_sleep_off: assert property ($rose(deep_sleep_out) |->
    ##[0:1] !supplies_on_out ##1 !supplies_on_out [*8])
    else $error("supplies on in sleep");
  a_cs_ignore: assert property (s_cs_idle |=> !ram_wr_out.wr_en)
    else $error("write without chip select");
  a_wr_pulse: assert property (ram_wr_out.wr_en |=> !ram_wr_out.wr_en)
    else $error("write strobe too long");
endmodule
bind epaper_spi_command_port epd_port_sva #(
  .REFRESH_CYCLES(REFRESH_CYCLES)
) epd_port_sva_i (
  .core_clk_in, .arst_n_in, .cs_n_in, .otp_busy_in, .sensor_busy_in,
  .serial_data_line_oe_out, .reserved_data_line_a_oe_out,
  .reserved_data_line_b_oe_out, .reserved_data_line_c_oe_out,
  .busy_n_out, .supplies_on_out, .deep_sleep_out, .refresh_active_out,
  .ram_wr_out
);

/* File: test/spi_host_model.sv */
`timescale 1ns/1ps
module spi_host_model (
  input wire logic core_clk_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic dc_out,
  output logic sdata_out
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    dc_out = 1'b0;
    sdata_out = 1'b0;
  end
  // Slow serial clock: the port samples it through synchronisers
  task automatic send(input logic three, input logic sel,
                      input logic dat, input logic [7:0] v);
    logic [8:0] frame;
    int n;
    frame = {dat, v};
    n = three ? 9 : 8;
    @(posedge core_clk_in);
    cs_n_out <= ~sel;
    // Unused in 3-line mode, driven wrong to prove it is ignored
    dc_out <= three ? ~dat : dat;
    for (int i = n - 1; i >= 0; i--) begin
      sdata_out <= frame[i];
      repeat (4) @(posedge core_clk_in);
      sclk_out <= 1'b1;
      repeat (4) @(posedge core_clk_in);
      sclk_out <= 1'b0;
    end
    repeat (4) @(posedge core_clk_in);
    cs_n_out <= 1'b1;
    sdata_out <= ~sdata_out;
    repeat (4) @(posedge core_clk_in);
  endtask
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("CHECK FAILED t=%0t %s", $time, msg); \
    end \
  end
module tb_top;
  localparam int RCYC = 20;
  logic core_clk_in = 1'b0;
  logic arst_n_in, clk_en_in, cs_n_in, sclk_in, dc_in;
  logic serial_data_line_in, junk_r, three_r;
  logic interface_strap_a_in, interface_strap_b_in;
  logic otp_busy_in, sensor_busy_in;
  logic busy_n_out, supplies_on_out, deep_sleep_out, refresh_active_out;
  epd_cmd_pkg::ram_write_t ram_wr_out;
  logic [25:0] wq[$];
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int low_n = 0;
  always #5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    junk_r <= ~junk_r;
    if (ram_wr_out.wr_en === 1'b1) wq.push_back(ram_wr_out[25:0]);
    if (busy_n_out === 1'b0) low_n++;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
  spi_host_model spi_host_model_i (.core_clk_in, .cs_n_out(cs_n_in),
    .sclk_out(sclk_in), .dc_out(dc_in), .sdata_out(serial_data_line_in));
  epaper_spi_command_port #(.REFRESH_CYCLES(RCYC)) epaper_spi_command_port_i (
    .core_clk_in, .arst_n_in, .clk_en_in, .cs_n_in, .sclk_in, .dc_in,
    .serial_data_line_in, .reserved_data_line_a_in(junk_r),
    .reserved_data_line_b_in(~junk_r), .reserved_data_line_c_in(junk_r),
    .interface_strap_a_in, .interface_strap_b_in, .otp_busy_in,
    .sensor_busy_in, .serial_data_line_out(), .serial_data_line_oe_out(),
    .reserved_data_line_a_out(), .reserved_data_line_a_oe_out(),
    .reserved_data_line_b_out(), .reserved_data_line_b_oe_out(),
    .reserved_data_line_c_out(), .reserved_data_line_c_oe_out(),
    .busy_n_out, .supplies_on_out, .deep_sleep_out, .refresh_active_out,
    .ram_wr_out);
  task automatic complete_run();
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic tx(input logic sel, input logic dat, input logic [7:0] v);
    spi_host_model_i.send(three_r, sel, dat, v);
    repeat (8) @(posedge core_clk_in);
  endtask
  task automatic hw_reset(input logic a, input logic b);
    @(posedge core_clk_in);
    arst_n_in <= 1'b0;
    interface_strap_a_in <= a;
    interface_strap_b_in <= b;
    three_r = a & ~b;
    repeat (12) @(posedge core_clk_in);
    `CHK(busy_n_out, 1'b1, "reset busy")
    `CHK(deep_sleep_out, 1'b0, "reset sleep")
    `CHK(ram_wr_out, '0, "reset ram port")
    arst_n_in <= 1'b1;
    repeat (8) @(posedge core_clk_in);
  endtask
  task automatic s_power();
    tx(1, 1, epd_cmd_pkg::CMD_POWER_ON);
    `CHK(supplies_on_out, 1'b0, "code sent as data")
    tx(1, 0, epd_cmd_pkg::CMD_POWER_ON);
    `CHK(supplies_on_out, 1'b1, "power on")
    tx(1, 0, epd_cmd_pkg::CMD_POWER_OFF);
    tx(1, 1, 8'h05);
    `CHK(supplies_on_out, 1'b1, "bad off param")
    tx(1, 0, epd_cmd_pkg::CMD_POWER_OFF);
    tx(1, 1, epd_cmd_pkg::PARAM_POWER_OFF);
    `CHK(supplies_on_out, 1'b0, "power off")
  endtask
  task automatic s_stream();
    wq.delete();
    tx(1, 0, epd_cmd_pkg::CMD_DATA_START);
    for (int i = 0; i < 3; i++) tx(1, 1, 8'ha0 + 8'(i));
    tx(0, 1, 8'hee);
    tx(1, 0, epd_cmd_pkg::CMD_POWER_ON);
    tx(1, 1, 8'h77);
    `CHK(wq.size(), 3, "write count")
    for (int i = 0; i < 3; i++) begin
      `CHK(wq[i], {18'(i), 8'ha0 + 8'(i)}, "ram write")
    end
  endtask
  task automatic s_refresh();
    int n;
    low_n = 0;
    tx(1, 0, epd_cmd_pkg::CMD_POWER_OFF);
    tx(1, 1, epd_cmd_pkg::PARAM_POWER_OFF);
    `CHK(supplies_on_out, 1'b0, "off before refresh")
    tx(1, 0, epd_cmd_pkg::CMD_REFRESH);
    tx(1, 1, 8'h02);
    `CHK(low_n, 0, "bad refresh param")
    tx(1, 0, epd_cmd_pkg::CMD_REFRESH);
    tx(1, 1, epd_cmd_pkg::PARAM_REFRESH);
    `CHK(refresh_active_out, 1'b1, "refresh running")
    `CHK(busy_n_out, 1'b0, "busy in refresh")
    n = 0;
    // Host holds off until busy returns high
    while (busy_n_out !== 1'b1 && n < 100) begin
      @(posedge core_clk_in);
      n++;
    end
    `CHK(low_n >= RCYC - 1 && low_n <= RCYC + 1, 1'b1, "refresh time")
    tx(1, 0, epd_cmd_pkg::CMD_POWER_ON);
    `CHK(supplies_on_out, 1'b1, "command after busy")
  endtask
  task automatic s_bg();
    for (int k = 0; k < 2; k++) begin
      otp_busy_in <= (k == 0);
      sensor_busy_in <= (k == 1);
      repeat (6) @(posedge core_clk_in);
      `CHK(busy_n_out, 1'b0, "background busy")
      otp_busy_in <= 1'b0;
      sensor_busy_in <= 1'b0;
      repeat (6) @(posedge core_clk_in);
      `CHK(busy_n_out, 1'b1, "background done")
    end
  endtask
  task automatic s_sleep();
    tx(1, 0, epd_cmd_pkg::CMD_DEEP_SLEEP);
    tx(1, 1, 8'h5a);
    `CHK(deep_sleep_out, 1'b0, "bad sleep key")
    tx(1, 0, epd_cmd_pkg::CMD_DEEP_SLEEP);
    tx(1, 1, epd_cmd_pkg::PARAM_DEEP_SLEEP);
    `CHK(deep_sleep_out, 1'b1, "sleep")
    `CHK(supplies_on_out, 1'b0, "sleep supplies")
    tx(1, 0, epd_cmd_pkg::CMD_POWER_ON);
    `CHK(supplies_on_out, 1'b0, "no serial wake")
    hw_reset(1'b0, 1'b0);
    `CHK(deep_sleep_out, 1'b0, "reset wake")
  endtask
  task automatic s_modes();
    hw_reset(1'b1, 1'b0);
    wq.delete();
    tx(1, 0, epd_cmd_pkg::CMD_DATA_START);
    tx(1, 1, 8'h3c);
    tx(1, 0, epd_cmd_pkg::CMD_POWER_ON);
    `CHK(wq.size(), 1, "nine-bit write count")
    `CHK(wq[0], {18'h00000, 8'h3c}, "nine-bit frame")
    `CHK(supplies_on_out, 1'b1, "nine-bit command")
    hw_reset(1'b1, 1'b1);
    // Frozen port must miss a whole frame
    clk_en_in <= 1'b0;
    tx(1, 0, epd_cmd_pkg::CMD_POWER_ON);
    `CHK(supplies_on_out, 1'b0, "frozen port")
    clk_en_in <= 1'b1;
    tx(1, 0, epd_cmd_pkg::CMD_POWER_ON);
    `CHK(supplies_on_out, 1'b1, "strap b picks 4-line")
  endtask
  initial begin
    arst_n_in = 1'b0;
    clk_en_in = 1'b1;
    junk_r = 1'b0;
    three_r = 1'b0;
    interface_strap_a_in = 1'b0;
    interface_strap_b_in = 1'b0;
    otp_busy_in = 1'b0;
    sensor_busy_in = 1'b0;
    hw_reset(1'b0, 1'b0);
    s_power();
    s_stream();
    s_refresh();
    s_bg();
    s_sleep();
    s_modes();
    complete_run();
  end
endmodule
